// [hw/pcrg_pkg.sv]
package pcrg_pkg;
   // Clock and time base
   localparam int unsigned CLK_FREQ_KHZ       = 10_000;
   localparam int unsigned REF_FREQ_KHZ       = 24_576;
   localparam int unsigned DSP_MAX_KHZ_SLOW   = 147_456;
   localparam int unsigned DSP_MAX_KHZ_FAST   = 159_744;
   // Multiplier range
   localparam logic [3:0]  MULT_MIN           = 4'h4;
   localparam logic [3:0]  MULT_MAX           = 4'hF;
   // Reset stretch after external release, least time
   localparam int unsigned RST_STRETCH_NS     = 20_000;
   localparam int unsigned RST_STRETCH_CYC    =
      (RST_STRETCH_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
   // Dead gap with both clocks gated during a source switch
   localparam int unsigned SWITCH_GAP_NS      = 400;
   localparam int unsigned SWITCH_GAP_CYC     =
      (SWITCH_GAP_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
   localparam int unsigned CNT_W              = 8;
   // Divider widths and reset values
   localparam int unsigned DIV_W              = 8;
   localparam logic [7:0]  DIV_RESET          = 8'h00;
   localparam logic [3:0]  MULT_RESET         = 4'h4;
   localparam logic [3:0]  BOOT_RESET         = 4'h0;
   // Synchroniser bit positions
   localparam int unsigned SY_EXT_RST_N       = 0;
   localparam int unsigned SY_PLL_OK          = 1;
   localparam int unsigned SY_CORE_OK         = 2;
   localparam int unsigned SY_PWM_OK          = 3;
   localparam int unsigned SY_LOCK            = 4;
   localparam int unsigned SY_REF             = 5;
   localparam int unsigned SY_BOOT            = 6;
   localparam int unsigned SY_W               = 10;
   localparam logic [9:0]  SY_RESET           = 10'h001;

   typedef enum logic [1:0] {
      PCRG_BYPASS,
      PCRG_WAIT_LOCK,
      PCRG_GAP,
      PCRG_PLL_RUN
   } pcrg_clk_state_t;
endpackage : pcrg_pkg

// [hw/pcrg_div.sv]
`timescale 1ns/1ps
// Programmable divider: one pulse every (i_ratio + 1) ticks
module pcrg_div #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Control
   input  wire logic             i_clr,
   input  wire logic             i_tick,
   input  wire logic [WIDTH-1:0] i_ratio,
   // Output
   output logic                  o_pulse
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;
   logic             pulse_reg;
   logic             pulse_next;

   always_comb begin
      cnt_next   = cnt_reg;
      pulse_next = 1'b0;
      if (i_clr) begin
         cnt_next = '0;
      end else if (i_tick) begin
         if (cnt_reg >= i_ratio) begin
            cnt_next   = '0;
            pulse_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_reg   <= '0;
         pulse_reg <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         pulse_reg <= pulse_next;
      end
   end

   assign o_pulse = pulse_reg;
endmodule : pcrg_div

// [hw/pcrg_top.sv]
`timescale 1ns/1ps
// What this block does
// - PLL output equals reference times 4..15
// - Bypass PLL until configured and locked
// - PLL clock times PWM, feeds DSP clock
// - Power-on pulse on PLL rail rising
// - Power-on reset drives reset output low
// - Core or PWM rail brown-out drives reset low
// - External low or power-on pulse starts reset
// - Counter stretches reset after external release
// - System clock comes from crystal oscillator
// - Reference input forwarded to buffer output
// - Separate DSP, S/PDIF, ADC, master clocks
// - DSP clock capped at variant maximum
// - Shared reference gives common timebase
// - During reset: resets on, oscillator on, PLL off
// - On external release capture boot mode, boot
// - External reset input is active low
module pcrg_top (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Pins from the board
   input  wire logic       i_external_reset_in_low,
   input  wire logic       i_reference_clock_in,
   input  wire logic       i_pll_supply_rail,
   input  wire logic       i_core_supply_rail,
   input  wire logic       i_pwm_output_supply_rail,
   input  wire logic [3:0] i_boot_mode_pins,
   // Analog PLL status
   input  wire logic       i_pll_lock,
   // Firmware configuration
   input  wire logic       i_fw_pll_request,
   input  wire logic [3:0] i_fw_pll_mult,
   input  wire logic [7:0] i_fw_dsp_div,
   input  wire logic [7:0] i_fw_spdif_div,
   input  wire logic [7:0] i_fw_adc_div,
   input  wire logic [7:0] i_fw_mclk_div,
   input  wire logic       i_fast_variant,
   // Reset and boot outputs
   output logic            o_system_reset_out_low,
   output logic            o_internal_reset,
   output logic            o_boot_start,
   output logic [3:0]      o_boot_mode,
   // Clock control outputs
   output logic            o_osc_enable,
   output logic            o_pll_enable,
   output logic [3:0]      o_pll_mult,
   output logic            o_clk_sel_pll,
   output logic            o_clk_gate,
   output logic            o_cfg_error,
   output logic            o_reference_clock_buffer_out,
   // Derived clock enables
   output logic            o_pwm_tick,
   output logic            o_dsp_clk_en,
   output logic            o_spdif_clk_en,
   output logic            o_adc_clk_en,
   output logic            o_mclk_en
);
   localparam logic [7:0] STRETCH = 8'(pcrg_pkg::RST_STRETCH_CYC);
   localparam logic [7:0] GAP     = 8'(pcrg_pkg::SWITCH_GAP_CYC);

   // Synchronisers for every pin and analog input
   logic [9:0] sy1_reg;
   logic [9:0] sy2_reg;
   logic [9:0] sy_next;
   logic       pll_ok_d_reg;

   always_comb begin
      sy_next = {i_boot_mode_pins, i_reference_clock_in, i_pll_lock,
                 i_pwm_output_supply_rail, i_core_supply_rail,
                 i_pll_supply_rail, i_external_reset_in_low};
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sy1_reg      <= pcrg_pkg::SY_RESET;
         sy2_reg      <= pcrg_pkg::SY_RESET;
         pll_ok_d_reg <= 1'b0;
      end else begin
         sy1_reg      <= sy_next;
         sy2_reg      <= sy1_reg;
         pll_ok_d_reg <= sy2_reg[pcrg_pkg::SY_PLL_OK];
      end
   end

   logic ext_rst;
   logic por_pulse;
   logic brown_out;
   logic locked;
   assign ext_rst   = ~sy2_reg[pcrg_pkg::SY_EXT_RST_N];
   assign por_pulse = sy2_reg[pcrg_pkg::SY_PLL_OK] & ~pll_ok_d_reg;
   assign brown_out = ~sy2_reg[pcrg_pkg::SY_CORE_OK] | ~sy2_reg[pcrg_pkg::SY_PWM_OK];
   assign locked    = sy2_reg[pcrg_pkg::SY_LOCK];
   // Reset sequencer
   logic       held_reg,      held_next;
   logic [7:0] cnt_reg,       cnt_next;
   logic       ext_d_reg,     ext_d_next;
   logic [3:0] boot_reg,      boot_next;
   logic       boot_go_reg,   boot_go_next;
   logic       rst_out_n_reg, rst_out_n_next;
   logic       irst_reg,      irst_next;
   logic       in_reset;
   always_comb begin
      held_next      = held_reg;
      cnt_next       = cnt_reg;
      ext_d_next     = ext_rst;
      boot_next      = boot_reg;
      boot_go_next   = 1'b0;
      if (ext_rst || por_pulse) begin
         held_next = 1'b1;
         cnt_next  = '0;
      end else if (held_reg) begin
         if (cnt_reg >= STRETCH - 8'h01) begin
            held_next    = 1'b0;
            boot_go_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 8'h01;
         end
      end
      if (ext_d_reg && !ext_rst) begin
         boot_next = sy2_reg[pcrg_pkg::SY_BOOT +: 4];
      end
      irst_next      = held_next | brown_out;
      rst_out_n_next = ~irst_next;
   end
   assign in_reset = held_reg | brown_out;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         held_reg      <= 1'b1;
         irst_reg      <= 1'b1;
         cnt_reg       <= '0;
         ext_d_reg     <= 1'b0;
         boot_reg      <= pcrg_pkg::BOOT_RESET;
         boot_go_reg   <= 1'b0;
         rst_out_n_reg <= 1'b0;
      end else begin
         held_reg      <= held_next;
         cnt_reg       <= cnt_next;
         ext_d_reg     <= ext_d_next;
         boot_reg      <= boot_next;
         boot_go_reg   <= boot_go_next;
         rst_out_n_reg <= rst_out_n_next;
         irst_reg      <= irst_next;
      end
   end
   // Clock source control
   pcrg_pkg::pcrg_clk_state_t st_reg, st_next;
   logic [7:0]  gap_reg,    gap_next;
   logic [3:0]  mult_reg,   mult_next;
   logic        err_reg,    err_next;
   logic        sel_reg,    sel_next;
   logic        gate_reg,   gate_next;
   logic        pll_en_reg, pll_en_next;
   logic        cfg_ok;
   logic [31:0] pll_khz;
   logic [31:0] dsp_cap;
   always_comb begin
      pll_khz = 32'(i_fw_pll_mult) * pcrg_pkg::REF_FREQ_KHZ;
      dsp_cap = (i_fast_variant ? pcrg_pkg::DSP_MAX_KHZ_FAST : pcrg_pkg::DSP_MAX_KHZ_SLOW)
                * (32'(i_fw_dsp_div) + 32'h0000_0001);
      cfg_ok  = (i_fw_pll_mult >= pcrg_pkg::MULT_MIN) && (i_fw_pll_mult <= pcrg_pkg::MULT_MAX)
                && (pll_khz <= dsp_cap);
   end
   always_comb begin
      st_next     = st_reg;
      gap_next    = gap_reg;
      mult_next   = mult_reg;
      err_next    = err_reg;
      sel_next    = sel_reg;
      gate_next   = gate_reg;
      pll_en_next = pll_en_reg;
      case (st_reg)
         pcrg_pkg::PCRG_BYPASS: begin
            sel_next  = 1'b0;
            gate_next = 1'b1;
            if (i_fw_pll_request) begin
               if (cfg_ok) begin
                  mult_next   = i_fw_pll_mult;
                  err_next    = 1'b0;
                  pll_en_next = 1'b1;
                  st_next     = pcrg_pkg::PCRG_WAIT_LOCK;
               end else begin
                  err_next = 1'b1;
               end
            end
         end
         pcrg_pkg::PCRG_WAIT_LOCK: begin
            if (!i_fw_pll_request) begin
               pll_en_next = 1'b0;
               st_next     = pcrg_pkg::PCRG_BYPASS;
            end else if (locked) begin
               gate_next = 1'b0;
               gap_next  = '0;
               st_next   = pcrg_pkg::PCRG_GAP;
            end
         end
         pcrg_pkg::PCRG_GAP: begin
            if (gap_reg >= GAP - 8'h01) begin
               gate_next = 1'b1;
               sel_next  = pll_en_reg & i_fw_pll_request & locked;
               st_next   = sel_next ? pcrg_pkg::PCRG_PLL_RUN : pcrg_pkg::PCRG_BYPASS;
               if (!sel_next) begin
                  pll_en_next = 1'b0;
               end
            end else begin
               gap_next = gap_reg + 8'h01;
               if (gap_reg == 8'h00) begin
                  sel_next = ~sel_reg;
               end
            end
         end
         pcrg_pkg::PCRG_PLL_RUN: begin
            if (!i_fw_pll_request || !locked) begin
               gate_next   = 1'b0;
               gap_next    = '0;
               st_next     = pcrg_pkg::PCRG_GAP;
            end
         end
         default: begin
            st_next = pcrg_pkg::PCRG_BYPASS;
         end
      endcase
      if (in_reset) begin
         st_next     = pcrg_pkg::PCRG_BYPASS;
         pll_en_next = 1'b0;
         sel_next    = 1'b0;
         gate_next   = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg     <= pcrg_pkg::PCRG_BYPASS;
         gap_reg    <= '0;
         mult_reg   <= pcrg_pkg::MULT_RESET;
         err_reg    <= 1'b0;
         sel_reg    <= 1'b0;
         gate_reg   <= 1'b1;
         pll_en_reg <= 1'b0;
      end else begin
         st_reg     <= st_next;
         gap_reg    <= gap_next;
         mult_reg   <= mult_next;
         err_reg    <= err_next;
         sel_reg    <= sel_next;
         gate_reg   <= gate_next;
         pll_en_reg <= pll_en_next;
      end
   end
   // Derived clocks from the selected source
   logic        pwm_reg, pwm_next;
   logic        ref_out_reg;
   logic        run_tick;
   logic [3:0]  div_pulse;
   logic [31:0] ratios;
   assign run_tick = gate_reg & ~in_reset;
   assign ratios   = {i_fw_mclk_div, i_fw_adc_div, i_fw_spdif_div, i_fw_dsp_div};
   always_comb begin
      pwm_next = run_tick & sel_reg;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pwm_reg     <= 1'b0;
         ref_out_reg <= 1'b0;
      end else begin
         pwm_reg     <= pwm_next;
         ref_out_reg <= sy2_reg[pcrg_pkg::SY_REF];
      end
   end
   for (genvar g = 0; g < 4; g++) begin : g_div
      pcrg_div #(.WIDTH (pcrg_pkg::DIV_W)) u_div (
         .i_clk   (i_clk),
         .i_rst   (i_rst),
         .i_clr   (in_reset),
         .i_tick  (run_tick),
         .i_ratio (ratios[g*8 +: 8]),
         .o_pulse (div_pulse[g])
      );
   end
   assign o_system_reset_out_low       = rst_out_n_reg;
   assign o_internal_reset             = irst_reg;
   assign o_boot_start                 = boot_go_reg;
   assign o_boot_mode                  = boot_reg;
   assign o_osc_enable                 = 1'b1;
   assign o_pll_enable                 = pll_en_reg;
   assign o_pll_mult                   = mult_reg;
   assign o_clk_sel_pll                = sel_reg;
   assign o_clk_gate                   = gate_reg;
   assign o_cfg_error                  = err_reg;
   assign o_reference_clock_buffer_out = ref_out_reg;
   assign o_pwm_tick                   = pwm_reg;
   assign o_dsp_clk_en                 = div_pulse[0];
   assign o_spdif_clk_en               = div_pulse[1];
   assign o_adc_clk_en                 = div_pulse[2];
   assign o_mclk_en                    = div_pulse[3];
endmodule : pcrg_top

// [test/pcrg_ref_model.sv]
`timescale 1ns/1ps
// Reference oscillator and analog PLL lock seen from the board side
module pcrg_ref_model #(
   parameter int unsigned HALF_CYC = 3,
   parameter int unsigned LOCK_CYC = 12
) (
   // Clock
   input  wire logic i_clk,
   // From the block
   input  wire logic i_pll_enable,
   // To the block
   output logic      o_ref,
   output logic      o_lock
);
   int unsigned ref_cnt_reg  = 0;
   int unsigned lock_cnt_reg = 0;
   logic        ref_reg      = 1'b0;
   logic        lock_reg     = 1'b0;

   assign o_ref  = ref_reg;
   assign o_lock = lock_reg;

   // Free-running reference, the same wave for every device sharing it
   always_ff @(posedge i_clk) begin
      ref_cnt_reg <= (ref_cnt_reg == HALF_CYC - 1) ? 0 : ref_cnt_reg + 1;
      ref_reg     <= (ref_cnt_reg == HALF_CYC - 1) ? ~ref_reg : ref_reg;
   end

   // Lock only after a settling time, lost as soon as the PLL is off
   always_ff @(posedge i_clk) begin
      lock_cnt_reg <= i_pll_enable ? lock_cnt_reg + 1 : 0;
      lock_reg     <= i_pll_enable && (lock_cnt_reg >= LOCK_CYC);
   end
endmodule : pcrg_ref_model

// [test/pcrg_top_chk.sv]
`timescale 1ns/1ps
module pcrg_top_chk (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Watched inputs
   input  wire logic       i_external_reset_in_low,
   input  wire logic       i_reference_clock_in,
   input  wire logic       i_core_supply_rail,
   input  wire logic       i_pwm_output_supply_rail,
   input  wire logic [7:0] i_fw_dsp_div,
   input  wire logic       i_fast_variant,
   // Watched outputs
   input  wire logic       o_system_reset_out_low,
   input  wire logic       o_internal_reset,
   input  wire logic       o_boot_start,
   input  wire logic       o_osc_enable,
   input  wire logic       o_pll_enable,
   input  wire logic [3:0] o_pll_mult,
   input  wire logic       o_clk_sel_pll,
   input  wire logic       o_clk_gate,
   input  wire logic       o_reference_clock_buffer_out,
   input  wire logic       o_pwm_tick
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_osc_running: assert property (o_osc_enable)
      else $error("oscillator stopped");
   a_reset_pll_off: assert property (o_internal_reset && $past(o_internal_reset)
      |-> !o_pll_enable && !o_clk_sel_pll) else $error("pll on in reset");
   a_ext_holds_reset: assert property (!i_external_reset_in_low [*4]
      |-> o_internal_reset && !o_system_reset_out_low) else $error("ext reset ignored");
   a_brownout_reset: assert property (!(i_core_supply_rail && i_pwm_output_supply_rail) [*4]
      |-> !o_system_reset_out_low && o_internal_reset) else $error("brownout ignored");
   a_boot_pulse: assert property (o_boot_start |-> $fell(o_internal_reset)
      ##1 !o_boot_start) else $error("boot start pulse wrong");
   a_mult_range: assert property (o_pll_enable |-> o_pll_mult >= pcrg_pkg::MULT_MIN)
      else $error("multiplier below range");
   a_sel_needs_pll: assert property (o_clk_sel_pll |-> o_pll_enable)
      else $error("pll selected while off");
   a_switch_gap: assert property ($fell(o_clk_gate) |-> !o_clk_gate [*4] ##1 o_clk_gate)
      else $error("switch gap length wrong");
   a_switch_gated: assert property ($changed(o_clk_sel_pll) |-> !o_clk_gate)
      else $error("source switched while clocks run");
   a_pwm_on_pll: assert property (o_pwm_tick |-> o_pll_enable)
      else $error("pwm tick without pll");
   a_dsp_cap: assert property (o_clk_sel_pll |-> 32'(o_pll_mult) * pcrg_pkg::REF_FREQ_KHZ
      <= (i_fast_variant ? pcrg_pkg::DSP_MAX_KHZ_FAST : pcrg_pkg::DSP_MAX_KHZ_SLOW)
      * (32'(i_fw_dsp_div) + 32'd1)) else $error("dsp clock above cap");
   a_ref_forward: assert property ($rose(i_reference_clock_in)
      |-> ##[2:4] o_reference_clock_buffer_out) else $error("reference not forwarded");
endmodule : pcrg_top_chk

bind pcrg_top pcrg_top_chk u_chk (.*);

// [test/pcrg_top_bench.sv]
`timescale 1ns/1ps
module pcrg_top_bench;
   logic       clk     = 1'b0;
   logic       rst     = 1'b1;
   logic       ext_n   = 1'b0;
   logic       pll_ok  = 1'b1;
   logic       core_ok = 1'b1;
   logic       pwm_ok  = 1'b1;
   logic [3:0] boot    = 4'h0;
   logic [3:0] mult    = 4'h4;
   logic       req     = 1'b0;
   logic       fast    = 1'b0;
   logic [7:0] dsp_div = 8'h00;
   logic       ref_clk, lock, sro_n, irst, boot_start, pll_en, sel, gate, cfg_err;
   logic       pwm_tick, dsp_en, spdif_en, adc_en, mclk_en;
   logic [3:0] boot_mode, pll_mult;
   int         errors      = 0;
   int         comparisons = 0;

   always #50 clk = ~clk;

   pcrg_ref_model u_ref (.i_clk(clk), .i_pll_enable(pll_en), .o_ref(ref_clk), .o_lock(lock));

   pcrg_top DUT (.i_clk(clk), .i_rst(rst), .i_external_reset_in_low(ext_n),
      .i_reference_clock_in(ref_clk), .i_pll_supply_rail(pll_ok),
      .i_core_supply_rail(core_ok), .i_pwm_output_supply_rail(pwm_ok),
      .i_boot_mode_pins(boot), .i_pll_lock(lock), .i_fw_pll_request(req),
      .i_fw_pll_mult(mult), .i_fw_dsp_div(dsp_div), .i_fw_spdif_div(8'h01),
      .i_fw_adc_div(8'h03), .i_fw_mclk_div(8'h07), .i_fast_variant(fast),
      .o_system_reset_out_low(sro_n), .o_internal_reset(irst), .o_boot_start(boot_start),
      .o_boot_mode(boot_mode), .o_osc_enable(), .o_pll_enable(pll_en), .o_pll_mult(pll_mult),
      .o_clk_sel_pll(sel), .o_clk_gate(gate), .o_cfg_error(cfg_err),
      .o_reference_clock_buffer_out(), .o_pwm_tick(pwm_tick), .o_dsp_clk_en(dsp_en),
      .o_spdif_clk_en(spdif_en), .o_adc_clk_en(adc_en), .o_mclk_en(mclk_en));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Cycles until internal reset drops, bounded
   task automatic wait_release(output int n);
      n = 0;
      while (irst !== 1'b0 && n < 400) begin
         cyc(1);
         n++;
      end
   endtask : wait_release

   // Wait for a source switch to finish, bounded
   task automatic wait_sel(input logic v);
      int n;
      n = 0;
      while (!(sel === v && gate === 1'b1) && n < 60) begin
         cyc(1);
         n++;
      end
   endtask : wait_sel

   task automatic t_boot;
      int n;
      @(posedge clk);
      boot  <= 4'hB;
      ext_n <= 1'b1;
      wait_release(n);
      chk(n >= 198 && n <= 206, 1'b1);
      chk(boot_start, 1'b1);
      chk(boot_mode, 4'hB);
      chk(sro_n, 1'b1);
      cyc(1);
      chk(boot_start, 1'b0);
   endtask : t_boot

   task automatic t_cfg(input logic [3:0] m, input logic [7:0] d, input logic f);
      logic ok;
      int   n;
      int   ns;
      int   na;
      int   nm;
      ok = m >= pcrg_pkg::MULT_MIN && 32'(m) * pcrg_pkg::REF_FREQ_KHZ <=
         (f ? pcrg_pkg::DSP_MAX_KHZ_FAST : pcrg_pkg::DSP_MAX_KHZ_SLOW) * (32'(d) + 1);
      @(posedge clk);
      mult    <= m;
      dsp_div <= d;
      fast    <= f;
      req     <= 1'b1;
      cyc(3);
      chk(pll_en, ok);
      chk(cfg_err, !ok);
      if (ok) begin
         wait_sel(1'b1);
         chk(sel, 1'b1);
         chk(pll_mult, m);
         n  = 0;
         ns = 0;
         na = 0;
         nm = 0;
         repeat (24) begin
            cyc(1);
            n  += int'(dsp_en === 1'b1 && pwm_tick === 1'b1);
            ns += int'(spdif_en === 1'b1);
            na += int'(adc_en === 1'b1);
            nm += int'(mclk_en === 1'b1);
         end
         chk(n, 24 / (d + 1));
         chk(ns, 12);
         chk(na, 6);
         chk(nm, 3);
      end
      @(posedge clk);
      req <= 1'b0;
      wait_sel(1'b0);
      cyc(2);
      chk(sel, 1'b0);
      chk(pll_en, 1'b0);
   endtask : t_cfg

   task automatic t_rails;
      int n;
      @(posedge clk);
      core_ok <= 1'b0;
      cyc(6);
      chk(sro_n, 1'b0);
      chk(irst, 1'b1);
      @(posedge clk);
      core_ok <= 1'b1;
      pwm_ok  <= 1'b0;
      cyc(6);
      chk(sro_n, 1'b0);
      @(posedge clk);
      pwm_ok <= 1'b1;
      pll_ok <= 1'b0;
      cyc(6);
      @(posedge clk);
      pll_ok <= 1'b1;
      cyc(6);
      chk(irst, 1'b1);
      chk(sro_n, 1'b0);
      wait_release(n);
      chk(n >= 185 && n <= 206, 1'b1);
   endtask : t_rails

   task automatic report_and_stop;
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(5);
      chk(irst, 1'b1);
      chk(sro_n, 1'b0);
      chk(pll_en, 1'b0);
      t_boot();
      t_cfg(4'h3, 8'h00, 1'b0);
      t_cfg(4'h6, 8'h00, 1'b1);
      t_cfg(4'h7, 8'h00, 1'b1);
      t_cfg(4'hF, 8'h02, 1'b0);
      t_rails();
      report_and_stop();
   end

   // Whole run is under 1500 cycles
   initial begin
      #(100 * 4000);
      errors++;
      report_and_stop();
   end
endmodule : pcrg_top_bench
